/* rtl/mmd_pkg.sv */
// Purpose: shared constants, types and helpers of the memory move decoder
// Assumes: 24-bit instruction word, 16-bit data memory, 24-bit program memory bus
// Notes:   register group map and non-data register widths are local choices
package mmd_pkg;

    localparam int MMD_IW      = 24;
    localparam int MMD_DW      = 16;
    localparam int MMD_AW      = 14;
    localparam int MMD_PMW     = 24;
    localparam int MMD_PX_W    = 8;
    localparam int MMD_NPTR    = 8;

    // Instruction field positions
    localparam int MMD_ADDR_LO = 4;
    localparam int MMD_ADDR_HI = 17;
    localparam int MMD_AMF_LO  = 13;
    localparam int MMD_AMF_HI  = 17;
    localparam int MMD_DREG_LO = 4;
    localparam int MMD_DREG_HI = 7;
    localparam int MMD_DAG_BIT = 20;
    localparam int MMD_RW_BIT  = 20;

    // Opcode patterns
    localparam logic [2:0] MMD_OP_DIRECT = 3'h4;
    localparam logic [2:0] MMD_OP_DM_IND = 3'h3;
    localparam logic [3:0] MMD_OP_PM_IND = 4'h5;
    localparam logic [4:0] MMD_AMF_NOP   = 5'h00;

    // Register groups and selectors
    localparam logic [1:0] MMD_GRP_DATA   = 2'h0;
    localparam logic [1:0] MMD_GRP_IDXMOD = 2'h1;
    localparam logic [1:0] MMD_GRP_LEN    = 2'h2;
    localparam logic [1:0] MMD_GRP_MISC   = 2'h3;
    localparam logic [3:0] MMD_DREG_MR_MID = 4'hB;
    localparam logic [3:0] MMD_DREG_MR_UP  = 4'hC;
    localparam logic [3:0] MMD_MISC_ARITH = 4'h0;
    localparam logic [3:0] MMD_MISC_MODE  = 4'h1;
    localparam logic [3:0] MMD_MISC_STACK = 4'h2;
    localparam logic [3:0] MMD_MISC_INTERRUPT_MASK = 4'h3;
    localparam logic [3:0] MMD_MISC_INTERRUPT_CONTROL = 4'h4;
    localparam logic [3:0] MMD_MISC_LOOP_COUNTER  = 4'h5;
    localparam logic [3:0] MMD_MISC_PX    = 4'h6;

    // Register widths
    localparam int MMD_W_PTR   = 14;
    localparam int MMD_W_ARITH = 8;
    localparam int MMD_W_MODE  = 7;
    localparam int MMD_W_STACK = 8;
    localparam int MMD_W_INTERRUPT_MASK = 5;
    localparam int MMD_W_INTERRUPT_CONTROL = 5;
    localparam int MMD_W_LOOP_COUNTER  = 14;
    localparam int MMD_W_MRU   = 8;

    // Values after reset
    localparam logic [13:0] MMD_RST_PTR   = 14'h0000;
    localparam logic [7:0]  MMD_RST_BYTE  = 8'h00;
    localparam logic [15:0] MMD_RST_WORD  = 16'h0000;
    localparam logic [7:0]  MMD_RST_STACK = 8'h55;

    typedef enum logic [2:0] {K_NONE, K_DIR_RD, K_DIR_WR, K_DM_IRD, K_PM_IRD} mmd_kind_t;
    typedef enum logic [1:0] {ST_IDLE, ST_ACCESS, ST_FINISH} mmd_state_t;

    typedef struct packed {
        mmd_kind_t   kind;
        logic [1:0]  grp;
        logic [3:0]  regsel;
        logic [13:0] addr;
        logic [4:0]  alu_mac_function_field;
        logic [2:0]  isel;
        logic [2:0]  msel;
    } mmd_dec_t;

    function automatic logic [15:0] mmd_extend(input logic [15:0] v, input int w,
                                               input logic sgn);
        logic [15:0] r;
        r = v;
        for (int i = 0; i < 16; i++)
        begin
            if (i >= w)
            begin
                r[i] = sgn ? v[w-1] : 1'b0;
            end
        end
        return r;
    endfunction : mmd_extend

    function automatic mmd_dec_t mmd_decode(input logic [23:0] ins);
        mmd_dec_t d;
        d        = '0;
        d.kind   = K_NONE;
        d.addr   = ins[MMD_ADDR_HI:MMD_ADDR_LO];
        d.alu_mac_function_field    = ins[MMD_AMF_HI:MMD_AMF_LO];
        d.grp    = MMD_GRP_DATA;
        d.regsel = ins[MMD_DREG_HI:MMD_DREG_LO];
        d.isel   = {ins[MMD_DAG_BIT], ins[3:2]};
        d.msel   = {ins[MMD_DAG_BIT], ins[1:0]};
        if (ins[23:21] == MMD_OP_DIRECT)
        begin
            d.grp    = ins[19:18];
            d.regsel = ins[3:0];
            d.kind   = ins[MMD_RW_BIT] ? K_DIR_WR : K_DIR_RD;
        end
        else if (ins[23:21] == MMD_OP_DM_IND && ins[19:18] == 2'h0 && ins[12:8] == 5'h00)
        begin
            d.kind = K_DM_IRD;
        end
        else if (ins[23:20] == MMD_OP_PM_IND && ins[19:18] == 2'h0 && ins[12:8] == 5'h00)
        begin
            d.kind = K_PM_IRD;
            d.isel = {1'b1, ins[3:2]};
            d.msel = {1'b1, ins[1:0]};
        end
        return d;
    endfunction : mmd_decode

endpackage : mmd_pkg

/* rtl/mmd_regfile.sv */
// Purpose: sixteen-word data register store with one write and one registered read port
// Assumes: read address sampled every edge; no same-cycle write/read of one word
// Notes:   contents are not reset, only the read register is
`timescale 1ns/1ps
module mmd_regfile
    import mmd_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        we,
    input  wire logic [3:0]  waddr,
    input  wire logic [15:0] wdata,
    input  wire logic [3:0]  raddr,
    output logic      [15:0] rdata_r
);
    logic [15:0] mem [16];

    always_ff @(posedge clk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            rdata_r <= MMD_RST_WORD;
        end
        else
        begin
            rdata_r <= mem[raddr];
        end
    end
endmodule : mmd_regfile

/* rtl/mmd_move_decode.sv */
// Purpose: decode and execute direct/indirect memory move instructions
// Assumes: memories answer read data in the cycle after the strobe cycle
// Notes:   every accepted legal instruction takes three cycles, ready falls meanwhile
// Notes on behaviour
// - Direct read: 14-bit address field; fetched word goes to group/select register.
// - Fetched data memory value lands right-justified, bit 0 to bit 0.
// - Indirect read addresses by chosen pointer, then adds chosen modify register.
// - Generator select bit picks both pointer and modify register together.
// - Zero arithmetic function code means no parallel arithmetic operation.
// - Indirect data register field picks exactly one of sixteen data registers.
// - Program read loads upper sixteen bus bits, bus bit 8 to bit 0.
// - Narrow destinations of program reads drop excess upper bits.
// - Every program read loads low bus byte into holding register.
// - Direct write: 14-bit address field, source from group/select register.
// - Narrow sources extend to sixteen bits: signed by sign, unsigned by zeros.
// - Pointer, length, counter, holding, flag and interrupt registers are unsigned.
// - Direct write stores source right-justified, bit 0 to bit 0.
// - Loading the middle mac result sign-extends into upper mac result.
`timescale 1ns/1ps
module mmd_move_decode
    import mmd_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        instr_valid,
    input  wire logic [23:0] instr,
    input  wire logic [15:0] dm_rdata,
    input  wire logic [23:0] pm_rdata,
    output logic             instr_ready,
    output logic      [13:0] dm_addr,
    output logic             dm_rd,
    output logic             dm_wr,
    output logic      [15:0] dm_wdata,
    output logic      [13:0] pm_addr,
    output logic             pm_rd,
    output logic             alu_req,
    output logic      [4:0]  alu_func,
    output logic             illegal_op,
    output logic             done,
    output logic             wb_valid,
    output logic      [1:0]  wb_group,
    output logic      [3:0]  wb_reg,
    output logic      [15:0] wb_data,
    output logic      [7:0]  low_byte,
    output logic      [7:0]  arith_flags,
    output logic      [7:0]  mac_upper
);
    mmd_state_t  st_r;
    mmd_dec_t    cur_r;
    mmd_dec_t    dec_now;
    logic        accept;
    logic [13:0] idx_r [MMD_NPTR];
    logic [13:0] mod_r [MMD_NPTR];
    logic [13:0] len_r [MMD_NPTR];
    logic [6:0]  mode_r;
    logic [7:0]  stack_r;
    logic [4:0]  interrupt_mask_r;
    logic [4:0]  interrupt_control_r;
    logic [13:0] loop_counter_r;
    logic [15:0] rf_rdata;
    logic        rf_we;
    logic [15:0] src_val;
    logic        src_unsig;
    logic        src_unsig_r;
    logic [15:0] rd_word;
    logic        fin_rd;

    assign dec_now = mmd_decode(instr);
    assign accept  = instr_valid && instr_ready;
    assign fin_rd  = (st_r == ST_FINISH) && cur_r.kind inside {K_DIR_RD, K_DM_IRD, K_PM_IRD};
    // Program bus bit 8 aligns with register bit 0
    assign rd_word = (cur_r.kind == K_PM_IRD) ? pm_rdata[23:8] : dm_rdata;
    // Only data register writes that are not the upper mac word land in the store
    assign rf_we   = fin_rd && cur_r.grp == MMD_GRP_DATA && cur_r.regsel != MMD_DREG_MR_UP;

    mmd_regfile u_regfile (
        .clk     (clk),
        .reset   (reset),
        .we      (rf_we),
        .waddr   (cur_r.regsel),
        .wdata   (rd_word),
        .raddr   (instr[3:0]),
        .rdata_r (rf_rdata)
    );

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            st_r        <= ST_IDLE;
            cur_r       <= '0;
            instr_ready <= 1'b0;
            illegal_op  <= 1'b0;
            done        <= 1'b0;
        end
        else
        begin
            illegal_op <= 1'b0;
            done       <= 1'b0;
            unique case (st_r)
                ST_IDLE:
                begin
                    instr_ready <= 1'b1;
                    if (accept)
                    begin
                        cur_r <= dec_now;
                        if (dec_now.kind == K_NONE)
                            illegal_op <= 1'b1;
                        else
                        begin
                            st_r        <= ST_ACCESS;
                            instr_ready <= 1'b0;
                        end
                    end
                end
                ST_ACCESS: st_r <= ST_FINISH;
                ST_FINISH:
                begin
                    st_r        <= ST_IDLE;
                    done        <= 1'b1;
                    instr_ready <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            dm_addr  <= MMD_RST_PTR;
            pm_addr  <= MMD_RST_PTR;
            dm_rd    <= 1'b0;
            pm_rd    <= 1'b0;
            dm_wr    <= 1'b0;
            dm_wdata <= MMD_RST_WORD;
            alu_req  <= 1'b0;
            alu_func <= MMD_AMF_NOP;
            src_unsig_r <= 1'b0;
        end
        else
        begin
            dm_rd   <= 1'b0;
            pm_rd   <= 1'b0;
            dm_wr   <= 1'b0;
            alu_req <= 1'b0;
            if (accept)
            begin
                unique case (dec_now.kind)
                    K_DIR_RD:
                    begin
                        dm_addr <= dec_now.addr;
                        dm_rd   <= 1'b1;
                    end
                    K_DIR_WR: dm_addr <= dec_now.addr;
                    K_DM_IRD:
                    begin
                        dm_addr <= idx_r[dec_now.isel];
                        dm_rd   <= 1'b1;
                    end
                    K_PM_IRD:
                    begin
                        pm_addr <= idx_r[dec_now.isel];
                        pm_rd   <= 1'b1;
                    end
                    K_NONE: ;
                endcase
                if (dec_now.kind inside {K_DM_IRD, K_PM_IRD} && dec_now.alu_mac_function_field != MMD_AMF_NOP)
                begin
                    alu_req  <= 1'b1;
                    alu_func <= dec_now.alu_mac_function_field;
                end
            end
            if (st_r == ST_ACCESS && cur_r.kind == K_DIR_WR)
            begin
                dm_wr       <= 1'b1;
                dm_wdata    <= src_val;
                src_unsig_r <= src_unsig;
            end
        end
    end

    always_comb
    begin
        src_unsig = 1'b1;
        src_val   = MMD_RST_WORD;
        unique case (cur_r.grp)
            MMD_GRP_DATA:
            begin
                src_unsig = 1'b0;
                if (cur_r.regsel == MMD_DREG_MR_UP)
                    src_val = mmd_extend({8'h00, mac_upper}, MMD_W_MRU, 1'b1);
                else
                    src_val = rf_rdata;
            end
            MMD_GRP_IDXMOD:
                if (cur_r.regsel[3])
                begin
                    src_unsig = 1'b0;
                    src_val   = mmd_extend({2'h0, mod_r[cur_r.regsel[2:0]]}, MMD_W_PTR, 1'b1);
                end
                else
                    src_val = {2'h0, idx_r[cur_r.regsel[2:0]]};
            MMD_GRP_LEN:
            begin
                src_val = cur_r.regsel[3] ? MMD_RST_WORD : {2'h0, len_r[cur_r.regsel[2:0]]};
            end
            MMD_GRP_MISC:
                case (cur_r.regsel)
                    MMD_MISC_ARITH: src_val = {8'h00, arith_flags};
                    MMD_MISC_MODE:  src_val = {9'h000, mode_r};
                    MMD_MISC_STACK: src_val = {8'h00, stack_r};
                    MMD_MISC_INTERRUPT_MASK: src_val = {11'h000, interrupt_mask_r};
                    MMD_MISC_INTERRUPT_CONTROL: src_val = {11'h000, interrupt_control_r};
                    MMD_MISC_LOOP_COUNTER:  src_val = {2'h0, loop_counter_r};
                    MMD_MISC_PX:    src_val = {8'h00, low_byte};
                    default:        src_val = MMD_RST_WORD;
                endcase
        endcase
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            for (int i = 0; i < MMD_NPTR; i++)
            begin
                idx_r[i] <= MMD_RST_PTR;
                mod_r[i] <= MMD_RST_PTR;
                len_r[i] <= MMD_RST_PTR;
            end
            arith_flags <= MMD_RST_BYTE;
            mode_r      <= 7'h00;
            stack_r     <= MMD_RST_STACK;
            interrupt_mask_r     <= 5'h00;
            interrupt_control_r     <= 5'h00;
            loop_counter_r      <= MMD_RST_PTR;
            low_byte    <= MMD_RST_BYTE;
            mac_upper   <= MMD_RST_BYTE;
        end
        else
        begin
            if (accept && dec_now.kind inside {K_DM_IRD, K_PM_IRD})
                idx_r[dec_now.isel] <= idx_r[dec_now.isel] + mod_r[dec_now.msel];
            if (fin_rd && cur_r.kind == K_PM_IRD)
                low_byte <= pm_rdata[7:0];
            if (fin_rd && cur_r.grp == MMD_GRP_DATA && cur_r.regsel == MMD_DREG_MR_UP)
                mac_upper <= rd_word[7:0];
            if (fin_rd && cur_r.grp == MMD_GRP_DATA && cur_r.regsel == MMD_DREG_MR_MID)
                mac_upper <= {8{rd_word[15]}};
            if (fin_rd && cur_r.kind == K_DIR_RD)
            begin
                unique case (cur_r.grp)
                    MMD_GRP_DATA: ;
                    MMD_GRP_IDXMOD:
                        if (cur_r.regsel[3])
                            mod_r[cur_r.regsel[2:0]] <= rd_word[13:0];
                        else
                            idx_r[cur_r.regsel[2:0]] <= rd_word[13:0];
                    MMD_GRP_LEN:
                        if (!cur_r.regsel[3])
                            len_r[cur_r.regsel[2:0]] <= rd_word[13:0];
                    MMD_GRP_MISC:
                        // Stack flags are read-only; a load into them is dropped
                        case (cur_r.regsel)
                            MMD_MISC_ARITH: arith_flags <= rd_word[7:0];
                            MMD_MISC_MODE:  mode_r      <= rd_word[6:0];
                            MMD_MISC_INTERRUPT_MASK: interrupt_mask_r     <= rd_word[4:0];
                            MMD_MISC_INTERRUPT_CONTROL: interrupt_control_r     <= rd_word[4:0];
                            MMD_MISC_LOOP_COUNTER:  loop_counter_r      <= rd_word[13:0];
                            MMD_MISC_PX:    low_byte    <= rd_word[7:0];
                            default: ;
                        endcase
                endcase
            end
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            wb_valid <= 1'b0;
            wb_group <= MMD_GRP_DATA;
            wb_reg   <= 4'h0;
            wb_data  <= MMD_RST_WORD;
        end
        else
        begin
            wb_valid <= fin_rd;
            if (fin_rd)
            begin
                wb_group <= cur_r.grp;
                wb_reg   <= cur_r.regsel;
                wb_data  <= rd_word;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_dir_rd_addr: assert property (accept && dec_now.kind == K_DIR_RD
        |=> dm_rd && dm_addr == $past(instr[17:4])) else $error("direct read address wrong");
    a_rd_justify: assert property (dm_rd
        |-> ##2 wb_valid && wb_data == $past(dm_rdata)) else $error("read data misplaced");
    a_ind_ptr: assert property (accept && dec_now.kind == K_DM_IRD
        |=> dm_addr == $past(idx_r[dec_now.isel])
            && idx_r[$past(dec_now.isel)] == $past(idx_r[dec_now.isel] + mod_r[dec_now.msel]))
        else $error("post-modify wrong");
    a_amf_nop: assert property (accept && dec_now.alu_mac_function_field == MMD_AMF_NOP
        |=> !alu_req) else $error("alu request on nop code");
    a_pm_align: assert property (pm_rd
        |-> ##2 wb_data == $past(pm_rdata[23:8]) && low_byte == $past(pm_rdata[7:0]))
        else $error("program read misaligned");
    a_pm_dag2: assert property (accept && dec_now.kind == K_PM_IRD
        |=> pm_addr == $past(idx_r[{1'b1, instr[3:2]}])) else $error("program read pointer");
    a_dir_wr_seq: assert property (accept && dec_now.kind == K_DIR_WR
        |=> !dm_wr && !dm_rd ##1 dm_wr && dm_addr == $past(instr[17:4], 2))
        else $error("direct write sequence");
    a_wr_zero_fill: assert property (dm_wr && src_unsig_r
        |-> dm_wdata[15:14] == 2'h0) else $error("unsigned source not zero filled");
    a_mr_mid_ext: assert property (wb_valid && wb_group == MMD_GRP_DATA
        && wb_reg == MMD_DREG_MR_MID |-> mac_upper == {8{wb_data[15]}})
        else $error("upper mac not sign extended");
    a_flags_hold: assert property (!$past(fin_rd && cur_r.grp == MMD_GRP_MISC)
        |-> $stable(arith_flags)) else $error("arithmetic flags changed");
    a_rw_bit: assert property (accept && instr[23:21] == MMD_OP_DIRECT
        |=> dm_rd == !$past(instr[20])) else $error("read/write bit misdecoded");

    c_dir_rd: cover property (accept && dec_now.kind == K_DIR_RD ##3 done);
    c_pm_rd:  cover property (pm_rd ##2 wb_valid);
    c_dir_wr: cover property (dm_wr && src_unsig_r);
    c_alu:    cover property (alu_req);
endmodule : mmd_move_decode

/* verif/mmd_mem_model.sv */
// Purpose: data and program memory seen by the move decoder
// Assumes: read word is wanted only in the cycle after the strobe
// Notes:   512 words each, address bits above 8 alias
`timescale 1ns/1ps
module mmd_mem_model
(
    input  wire logic        clk,
    input  wire logic [13:0] dm_addr,
    input  wire logic        dm_rd,
    input  wire logic        dm_wr,
    input  wire logic [15:0] dm_wdata,
    input  wire logic [13:0] pm_addr,
    input  wire logic        pm_rd,
    output logic      [15:0] dm_rdata,
    output logic      [23:0] pm_rdata
);
    logic [15:0] dm [0:511];
    logic [23:0] pm [0:511];

    initial
    begin
        for (int i = 0; i < 512; i++)
        begin
            dm[i] = 16'h5A00 ^ i[15:0];
            pm[i] = 24'hC30000 ^ i[23:0];
        end
        dm_rdata = 16'h0000;
        pm_rdata = 24'h000000;
    end

    // Outside the answer cycle the buses toggle so a late sample shows up
    always @(posedge clk)
    begin
        if (dm_wr)
            dm[dm_addr[8:0]] <= dm_wdata;
        dm_rdata <= dm_rd ? dm[dm_addr[8:0]] : ~dm_rdata;
        pm_rdata <= pm_rd ? pm[pm_addr[8:0]] : ~pm_rdata;
    end
endmodule : mmd_mem_model

/* verif/mmd_move_decode_tb_top.sv */
// Purpose: self-checking bench for the memory move decoder
// Assumes: one instruction in flight; results read in the done cycle
// Notes:   register loads go through direct reads of words at 0x100 up
`timescale 1ns/1ps
module mmd_move_decode_tb_top;
    logic        clk, reset, instr_valid, instr_ready, dm_rd, dm_wr, pm_rd;
    logic        alu_req, illegal_op, done, wb_valid;
    logic [23:0] instr, pm_rdata;
    logic [15:0] dm_rdata, dm_wdata, wb_data;
    logic [13:0] dm_addr, pm_addr;
    logic [7:0]  low_byte, arith_flags, mac_upper;
    logic [4:0]  alu_func;
    logic [3:0]  wb_reg;
    logic [1:0]  wb_group;
    logic        got_rd, got_wr, got_pm, got_alu, got_ill, got_done;
    int          fail_count, check_count;

    mmd_move_decode mmd_move_decode_inst (.clk(clk), .reset(reset),
        .instr_valid(instr_valid), .instr(instr), .dm_rdata(dm_rdata), .pm_rdata(pm_rdata),
        .instr_ready(instr_ready), .dm_addr(dm_addr), .dm_rd(dm_rd), .dm_wr(dm_wr),
        .dm_wdata(dm_wdata), .pm_addr(pm_addr), .pm_rd(pm_rd), .alu_req(alu_req),
        .alu_func(alu_func), .illegal_op(illegal_op), .done(done), .wb_valid(wb_valid),
        .wb_group(wb_group), .wb_reg(wb_reg), .wb_data(wb_data), .low_byte(low_byte),
        .arith_flags(arith_flags), .mac_upper(mac_upper));
    mmd_mem_model mmd_mem_model_inst (.clk(clk), .dm_addr(dm_addr), .dm_rd(dm_rd),
        .dm_wr(dm_wr), .dm_wdata(dm_wdata), .pm_addr(pm_addr), .pm_rd(pm_rd),
        .dm_rdata(dm_rdata), .pm_rdata(pm_rdata));

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : print_verdict

    task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic step;
        @(posedge clk);
        #2;
    endtask : step

    // Offers one word, then watches strobes until done or refusal
    task automatic exec(input logic [23:0] ins);
        {got_rd, got_wr, got_pm, got_alu, got_ill, got_done} = 6'h00;
        for (int n = 0; n < 10 && instr_ready !== 1'b1; n++)
            step();
        instr = ins;
        instr_valid = 1'b1;
        step();
        instr_valid = 1'b0;
        for (int n = 0; n < 6 && got_done == 1'b0 && got_ill == 1'b0; n++)
        begin
            got_rd |= (dm_rd === 1'b1);
            got_wr |= (dm_wr === 1'b1);
            got_pm |= (pm_rd === 1'b1);
            got_alu |= (alu_req === 1'b1);
            got_ill |= (illegal_op === 1'b1);
            got_done |= (done === 1'b1);
            if (got_done == 1'b0 && got_ill == 1'b0)
                step();
        end
    endtask : exec

    task automatic ld(input logic [1:0] g, input logic [3:0] r, input logic [15:0] v);
        logic [13:0] a;
        a = {8'h04, g, r};
        mmd_mem_model_inst.dm[a[8:0]] = v;
        exec({3'h4, 1'b0, g, a, r});
        chk("dm_addr", dm_addr, a);
        chk("wb_data", wb_data, v);
        chk("wb_dest", {wb_valid, got_rd, wb_group, wb_reg}, {2'b11, g, r});
    endtask : ld

    task automatic st(input logic [1:0] g, input logic [3:0] r, input logic [15:0] e);
        exec({3'h4, 1'b1, g, 14'h0F0 + r, r});
        chk("write_kind", {got_wr, got_rd}, 2'b10);
        chk("dm_addr", dm_addr, 14'h0F0 + r);
        chk("dm_wdata", dm_wdata, e);
    endtask : st

    task automatic ird(input logic g, input logic [4:0] f, input logic [3:0] d,
                       input logic [13:0] a, input logic [15:0] v);
        mmd_mem_model_inst.dm[a[8:0]] = v;
        exec({3'h3, g, 2'h0, f, 5'h00, d, 2'h1, 2'h1});
        chk("ind_addr", dm_addr, a);
        chk("ind_dest", {wb_group, wb_reg, wb_data}, {2'h0, d, v});
        chk("alu_req", got_alu, f != 5'h00);
    endtask : ird

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial
    begin
        repeat (3000) @(posedge clk);
        fail_count++;
        print_verdict();
    end

    initial
    begin
        reset = 1'b1;
        instr_valid = 1'b0;
        instr = 24'h000000;
        repeat (20) @(posedge clk);
        #2;
        reset = 1'b0;
        ld(2'h0, 4'h3, 16'hA55A);
        st(2'h0, 4'h3, 16'hA55A);
        ld(2'h1, 4'h8, 16'h2001);
        st(2'h1, 4'h8, 16'hE001);
        ld(2'h1, 4'h0, 16'h2001);
        st(2'h1, 4'h0, 16'h2001);
        ld(2'h3, 4'h5, 16'hFFFF);
        st(2'h3, 4'h5, 16'h3FFF);
        ld(2'h2, 4'h3, 16'hC123);
        st(2'h2, 4'h3, 16'h0123);
        ld(2'h0, 4'hB, 16'h8000);
        step();
        chk("mac_upper", mac_upper, 8'hFF);
        ld(2'h0, 4'hB, 16'h1234);
        step();
        chk("mac_upper", mac_upper, 8'h00);
        ld(2'h1, 4'h1, 16'h0040);
        ld(2'h1, 4'h9, 16'h0003);
        ld(2'h1, 4'h5, 16'h0090);
        ld(2'h1, 4'hD, 16'h0002);
        ird(1'b0, 5'h00, 4'h7, 14'h0040, 16'h1111);
        ird(1'b0, 5'h0A, 4'h2, 14'h0043, 16'h2222);
        chk("alu_func", alu_func, 5'h0A);
        ird(1'b1, 5'h00, 4'h4, 14'h0090, 16'h3333);
        ird(1'b1, 5'h1F, 4'hF, 14'h0092, 16'h4444);
        ld(2'h1, 4'h6, 16'h0050);
        mmd_mem_model_inst.pm[9'h050] = 24'hABCDEF;
        exec({4'h5, 2'h0, 5'h00, 5'h00, 4'hC, 2'h2, 2'h1});
        step();
        chk("pm_addr", {got_pm, pm_addr}, {1'b1, 14'h0050});
        chk("pm_word", wb_data, 16'hABCD);
        chk("low_byte", low_byte, 8'hEF);
        chk("mac_upper", mac_upper, 8'hCD);
        st(2'h0, 4'hC, 16'hFFCD);
        st(2'h3, 4'h6, 16'h00EF);
        mmd_mem_model_inst.pm[9'h052] = 24'h12F081;
        exec({4'h5, 2'h0, 5'h00, 5'h00, 4'h1, 2'h2, 2'h1});
        step();
        chk("pm_next_addr", pm_addr, 14'h0052);
        chk("pm_next", {wb_data, low_byte}, {16'h12F0, 8'h81});
        st(2'h0, 4'h1, 16'h12F0);
        st(2'h0, 4'h7, 16'h1111);
        exec(24'h640000);
        chk("refused", {got_ill, got_done, got_rd, instr_ready}, 4'b1001);
        exec(24'h540100);
        chk("refused", {got_ill, got_done, got_pm}, 3'b100);
        chk("arith_flags", arith_flags, 8'h00);
        print_verdict();
    end
endmodule : mmd_move_decode_tb_top
